// File: dpst_pkg.sv
// Package of shared constants and types for the digipot serial port.
package dpst_pkg;

  // ---------------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------------
  localparam int FRAME_BITS  = 16;
  localparam int CMD_MSB     = 15;
  localparam int CMD_LSB     = 12;
  localparam int WIPER_BITS  = 10;
  localparam int STORE_DEPTH = 20;
  localparam int STORE_IDX_W = 5;

  localparam logic [WIPER_BITS-1:0] WIPER_MIDSCALE = 10'h200;

  // ---------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    DPST_CMD_NOP      = 4'h0,
    DPST_CMD_WR_WIPER = 4'h1,
    DPST_CMD_RD_WIPER = 4'h2,
    DPST_CMD_PROGRAM  = 4'h3,
    DPST_CMD_RD_STORE = 4'h5,
    DPST_CMD_MODE     = 4'h6
  } dpst_cmd_t;

  // ---------------------------------------------------------------------
  // Timing, device clock (link clock) side
  // ---------------------------------------------------------------------
  localparam int LINK_PERIOD_PS   = 48000;
  localparam int T_WR_PERF_NS     = 2400;
  localparam int T_WR_NORM_NS     = 410;
  localparam int T_PROG_US        = 8000;
  localparam int T_RD_WIPER_NS    = 450;
  localparam int T_RD_STORE_US    = 1300;
  localparam int T_POWER_UP_US    = 2000;
  localparam int T_BUSY_FALL_NS   = 40;
  // Longest times round down to whole link cycles, never below one.
  localparam int WR_PERF_CYC  = (T_WR_PERF_NS * 1000) / LINK_PERIOD_PS;
  localparam int WR_NORM_CYC  = (T_WR_NORM_NS * 1000) / LINK_PERIOD_PS;
  localparam int RD_WIPER_CYC = (T_RD_WIPER_NS * 1000) / LINK_PERIOD_PS;
  localparam int PROG_CYC     = (T_PROG_US * 1000) / (LINK_PERIOD_PS / 1000);
  localparam int RD_STORE_CYC =
    (T_RD_STORE_US * 1000) / (LINK_PERIOD_PS / 1000);
  localparam int POWER_UP_CYC =
    (T_POWER_UP_US * 1000) / (LINK_PERIOD_PS / 1000);

  // ---------------------------------------------------------------------
  // Timing, host clock side
  // ---------------------------------------------------------------------
  localparam int HOST_PERIOD_NS = 50;
  localparam int T_SEL_HIGH_NS  = 400;
  localparam int T_RESET_NS     = 20;
  localparam int SEL_HIGH_CYC   =
    (T_SEL_HIGH_NS + HOST_PERIOD_NS - 1) / HOST_PERIOD_NS;
  localparam int RESET_CYC      =
    (T_RESET_NS + HOST_PERIOD_NS - 1) / HOST_PERIOD_NS;
  // Half period of the serial clock in host cycles. The device sees the
  // link only through three-flop synchronisers on its own clock, so each
  // clock level must span enough link cycles for readback to settle.
  localparam int SCLK_DIV       = 8;
  localparam int CNT_W          = 24;

endpackage : dpst_pkg

// File: dpst_if.sv
// Interface joining the serial host and the digipot device.
`timescale 1ns/1ps
interface dpst_if;
  logic sel_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic done;
  logic done_oe;
  logic reset_pin_n;

  modport device (
    input  sel_n, sclk, sdi, reset_pin_n,
    output sdo, sdo_oe, done, done_oe
  );
  modport host (
    output sel_n, sclk, sdi, reset_pin_n,
    input  sdo, sdo_oe, done, done_oe
  );
endinterface : dpst_if

// File: dpst_device.sv
// Device end: serial command port, busy timing and wiper restore.
// Function
// R1: Precision-mode wiper write busy at most 2.4us.
// R2: Normal-mode wiper write done within 410ns.
// R3: Store program busy at most 8ms.
// R4: Wiper readback done within 450ns.
// R5: Store readback busy at most 1.3ms.
// R6: Power-on restore within 2ms.
// R7: Host waits done high before selecting.
// R8: Done falls within 40ns of select rise; the device drops it four link edges after the rise.
// R9: Select stays high at least 400ns.
// R10: Clock idles low, sample on falling.
// R11: Serial clock at most 50MHz.
// R12: Reset pulse at least 20ns.
// R13: Readback bit valid within 450ns of rise.
// R14: Reset pin rise reloads wiper from store.
// R15: Unprogrammed store restores midscale code.
// R16: Done released when operation ends, high idle.
// R17: Frame from select fall to rise.
`timescale 1ns/1ps
module dpst_device
  import dpst_pkg::*;
#(
  parameter int unsigned PROG_CYCLES  = PROG_CYC,
  parameter int unsigned RDSTO_CYCLES = RD_STORE_CYC,
  parameter int unsigned PWRUP_CYCLES = POWER_UP_CYC
) (
  // Link clock and power-on reset
  input  wire logic                 link_clk,
  input  wire logic                 arst_n,
  // Link pins
  dpst_if.device                    bus,
  // User side
  output logic [WIPER_BITS-1:0]     wiper_setting,
  output logic                      perf_mode,
  output logic [STORE_IDX_W-1:0]    store_used
);
  import dpst_pkg::*;

  typedef enum logic [2:0] {
    DPST_ST_BOOT  = 3'b000,
    DPST_ST_IDLE  = 3'b001,
    DPST_ST_FRAME = 3'b010,
    DPST_ST_EXEC  = 3'b011
  } dpst_dev_state_t;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  // The device runs on the host's serial clock domain only as a sampled
  // level; every input pin passes three flops, and select, clock and reset count once the last two agree.
  logic [2:0] sel_s_q, clk_s_q, dat_s_q, rst_s_q;
  logic       sel_f_q, clk_f_q, rst_f_q;

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_s_q <= 3'h7;
      clk_s_q <= 3'h0;
      dat_s_q <= 3'h0;
      rst_s_q <= 3'h7;
    end
    else
    begin
      sel_s_q <= {sel_s_q[1:0], bus.sel_n};
      clk_s_q <= {clk_s_q[1:0], bus.sclk};
      dat_s_q <= {dat_s_q[1:0], bus.sdi};
      rst_s_q <= {rst_s_q[1:0], bus.reset_pin_n};
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_f_q <= 1'b1;
      clk_f_q <= 1'b0;
      rst_f_q <= 1'b1;
    end
    else
    begin
      if (sel_s_q[1] == sel_s_q[2]) sel_f_q <= sel_s_q[2];
      if (clk_s_q[1] == clk_s_q[2]) clk_f_q <= clk_s_q[2];
      if (rst_s_q[1] == rst_s_q[2]) rst_f_q <= rst_s_q[2];
    end
  end

  logic sel_agree, clk_agree, rst_agree;
  assign sel_agree = (sel_s_q[1] == sel_s_q[2]);
  assign clk_agree = (clk_s_q[1] == clk_s_q[2]);
  assign rst_agree = (rst_s_q[1] == rst_s_q[2]);

  logic sel_fall, sel_rise, clk_rise, clk_fall, rst_rise;
  assign sel_fall = sel_agree && sel_f_q && !sel_s_q[2];
  assign sel_rise = sel_agree && !sel_f_q && sel_s_q[2];  // R17
  assign clk_rise = clk_agree && !clk_f_q && clk_s_q[2];
  assign clk_fall = clk_agree && clk_f_q && !clk_s_q[2];  // R10
  assign rst_rise = rst_agree && !rst_f_q && rst_s_q[2];  // R14

  // ---------------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------------
  dpst_dev_state_t               state_q;
  logic [CNT_W-1:0]              wait_q;
  logic [FRAME_BITS-1:0]         shift_q;
  logic [FRAME_BITS-1:0]         out_q;
  logic [WIPER_BITS-1:0]         wiper_setting_reg_q;
  logic [WIPER_BITS-1:0]         limited_program_store [STORE_DEPTH];
  logic [STORE_IDX_W-1:0]        used_q;
  logic                          perf_q;
  logic                          readout_q;
  logic                          restore_q;

  dpst_cmd_t             cmd;
  logic [CNT_W-1:0]      exec_cycles;
  assign cmd = dpst_cmd_t'(shift_q[CMD_MSB:CMD_LSB]);

  always_comb
  begin
    exec_cycles = CNT_W'(1);
    case (cmd)
      DPST_CMD_WR_WIPER:
        exec_cycles = perf_q ? CNT_W'(WR_PERF_CYC)         // R1
                             : CNT_W'(WR_NORM_CYC);        // R2
      DPST_CMD_RD_WIPER: exec_cycles = CNT_W'(RD_WIPER_CYC); // R4
      DPST_CMD_PROGRAM:  exec_cycles = CNT_W'(PROG_CYCLES);  // R3
      DPST_CMD_RD_STORE: exec_cycles = CNT_W'(RDSTO_CYCLES); // R5
      default:           exec_cycles = CNT_W'(1);
    endcase
  end

  // Last programmed entry, or midscale while none is programmed.
  logic [WIPER_BITS-1:0] restore_val;
  assign restore_val = (used_q == '0) ? WIPER_MIDSCALE              // R15
                     : limited_program_store[used_q - 5'h01];

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= DPST_ST_BOOT;
      wait_q    <= '0;
      shift_q   <= '0;
      readout_q <= 1'b0;
      restore_q <= 1'b0;
    end
    else
    begin
      restore_q <= 1'b0;
      case (state_q)
        DPST_ST_BOOT:
        begin
          wait_q <= wait_q + CNT_W'(1);
          if (wait_q >= CNT_W'(PWRUP_CYCLES - 1))                  // R6
          begin
            restore_q <= 1'b1;
            state_q   <= DPST_ST_IDLE;
          end
        end
        DPST_ST_IDLE:
          if (sel_fall)
          begin
            shift_q <= '0;
            state_q <= DPST_ST_FRAME;
          end
        DPST_ST_FRAME:
        begin
          if (clk_fall)
            shift_q <= {shift_q[FRAME_BITS-2:0], dat_s_q[2]};      // R10
          if (sel_rise)
          begin
            wait_q    <= exec_cycles;
            readout_q <= (cmd == DPST_CMD_RD_WIPER) ||
                         (cmd == DPST_CMD_RD_STORE);
            state_q   <= DPST_ST_EXEC;                             // R17
          end
        end
        DPST_ST_EXEC:
        begin
          wait_q <= wait_q - CNT_W'(1);
          if (wait_q <= CNT_W'(1))
            state_q <= DPST_ST_IDLE;                               // R16
        end
        default: state_q <= DPST_ST_IDLE;
      endcase
      // A reset pin rise reloads the wiper regardless of frame state.
      if (rst_rise)
        restore_q <= 1'b1;                                         // R14
    end
  end

  // ---------------------------------------------------------------------
  // Wiper, mode and store
  // ---------------------------------------------------------------------
  logic exec_done;
  assign exec_done = (state_q == DPST_ST_EXEC) && (wait_q <= CNT_W'(1));

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wiper_setting_reg_q <= WIPER_MIDSCALE;
      perf_q              <= 1'b0;
    end
    else if (restore_q)
      wiper_setting_reg_q <= restore_val;                          // R14
    else if (exec_done)
    begin
      if (cmd == DPST_CMD_WR_WIPER)
        wiper_setting_reg_q <= shift_q[WIPER_BITS-1:0];
      if (cmd == DPST_CMD_MODE)
        perf_q <= shift_q[0];
    end
  end

  // Entries are one-time; once all are used further programs are ignored.
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      used_q <= '0;
    else if (exec_done && cmd == DPST_CMD_PROGRAM &&
             used_q < STORE_IDX_W'(STORE_DEPTH))
      used_q <= used_q + 5'h01;                                    // R3
  end

  genvar gi;
  generate
    for (gi = 0; gi < STORE_DEPTH; gi++)
    begin : g_store
      always_ff @(posedge link_clk or negedge arst_n)
      begin
        if (!arst_n)
          limited_program_store[gi] <= WIPER_MIDSCALE;
        else if (exec_done && cmd == DPST_CMD_PROGRAM &&
                 used_q == STORE_IDX_W'(gi))
          limited_program_store[gi] <= wiper_setting_reg_q;
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Readback shifter
  // ---------------------------------------------------------------------
  // Readback data belongs to the frame after the read command.
  // Each bit is launched on a rising clock edge and holds to the next.
  logic sdo_q;
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_q <= '0;
      sdo_q <= 1'b0;
    end
    else if (exec_done && readout_q)
      out_q <= FRAME_BITS'(cmd == DPST_CMD_RD_WIPER ? wiper_setting_reg_q
                                                    : restore_val);
    else if (state_q == DPST_ST_FRAME && clk_rise)
    begin
      sdo_q <= out_q[FRAME_BITS-1];                                // R13
      out_q <= {out_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------------
  // Pins and user outputs
  // ---------------------------------------------------------------------
  logic done_q;
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      done_q <= 1'b0;
    else if (sel_rise && state_q == DPST_ST_FRAME)
      done_q <= 1'b0;                                              // R8
    else
      done_q <= (state_q == DPST_ST_IDLE) || (state_q == DPST_ST_FRAME) ||
                (exec_done && !restore_q);                         // R16
  end

  assign bus.done    = done_q;
  assign bus.done_oe = 1'b1;
  assign bus.sdo     = sdo_q;
  assign bus.sdo_oe  = !sel_f_q;
  assign wiper_setting = wiper_setting_reg_q;
  assign perf_mode     = perf_q;
  assign store_used    = used_q;

endmodule : dpst_device

// File: dpst_host.sv
// Host end: frames commands, drives the serial clock and reset pin.
`timescale 1ns/1ps
module dpst_host
  import dpst_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // Command port
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire logic [FRAME_BITS-1:0]   cmd_frame,
  input  wire logic                    pin_reset_req,
  output logic [FRAME_BITS-1:0]        rsp_data,
  output logic                         rsp_valid,
  // Link pins
  dpst_if.host                         bus
);
  import dpst_pkg::*;

  typedef enum logic [1:0] {
    DPST_H_IDLE  = 2'b00,
    DPST_H_SHIFT = 2'b01,
    DPST_H_GAP   = 2'b10
  } dpst_host_state_t;

  // ---------------------------------------------------------------------
  // Done synchroniser
  // ---------------------------------------------------------------------
  logic [2:0] done_s_q;
  logic [2:0] sdo_s_q;
  logic       done_f_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done_s_q <= 3'h0;
      sdo_s_q  <= 3'h0;
      done_f_q <= 1'b0;
    end
    else
    begin
      done_s_q <= {done_s_q[1:0], bus.done};
      sdo_s_q  <= {sdo_s_q[1:0], bus.sdo};
      if (done_s_q[1] == done_s_q[2])
        done_f_q <= done_s_q[2];
    end
  end

  // ---------------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------------
  dpst_host_state_t          state_q;
  logic [FRAME_BITS-1:0]     tx_q, rx_q;
  logic [4:0]                bit_q;
  logic [CNT_W-1:0]          cnt_q;
  logic                      sclk_q, sel_n_q, sdi_q;

  // The gap also covers the done resync delay so R7 holds.
  assign cmd_ready = (state_q == DPST_H_IDLE) && done_f_q;          // R7

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= DPST_H_IDLE;
      tx_q      <= '0;
      rx_q      <= '0;
      bit_q     <= '0;
      cnt_q     <= '0;
      sclk_q    <= 1'b0;
      sel_n_q   <= 1'b1;
      sdi_q     <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_q)
        DPST_H_IDLE:
          if (cmd_valid && cmd_ready)
          begin
            tx_q    <= cmd_frame;
            bit_q   <= 5'(FRAME_BITS);
            cnt_q   <= '0;
            sel_n_q <= 1'b0;
            state_q <= DPST_H_SHIFT;
          end
        DPST_H_SHIFT:
        begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(SCLK_DIV - 1))
          begin
            cnt_q  <= '0;
            sclk_q <= !sclk_q;                                     // R11
            if (!sclk_q)
            begin
              sdi_q <= tx_q[FRAME_BITS-1];                         // R10
              tx_q  <= {tx_q[FRAME_BITS-2:0], 1'b0};
            end
            else
            begin
              rx_q  <= {rx_q[FRAME_BITS-2:0], sdo_s_q[2]};         // R13
              bit_q <= bit_q - 5'h01;
              if (bit_q == 5'h01)
                state_q <= DPST_H_GAP;
            end
          end
        end
        DPST_H_GAP:
        begin
          cnt_q <= cnt_q + CNT_W'(1);
          // Select rises half a clock period after the last fall, so the
          // device has taken the last bit before execution starts.
          if (cnt_q == CNT_W'(SCLK_DIV - 1))
            sel_n_q <= 1'b1;                                       // R17
          if (cnt_q >= CNT_W'(SCLK_DIV + SEL_HIGH_CYC + 4))        // R9
          begin
            rsp_data  <= rx_q;
            rsp_valid <= 1'b1;
            state_q   <= DPST_H_IDLE;
          end
        end
        default: state_q <= DPST_H_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Reset pin pulse
  // ---------------------------------------------------------------------
  logic [3:0] rst_cnt_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_cnt_q <= '0;
    else if (pin_reset_req && rst_cnt_q == '0)
      rst_cnt_q <= 4'(RESET_CYC + 2);                              // R12
    else if (rst_cnt_q != '0)
      rst_cnt_q <= rst_cnt_q - 4'h1;
  end

  assign bus.sel_n       = sel_n_q;
  assign bus.sclk        = sclk_q;
  assign bus.sdi         = sdi_q;
  assign bus.reset_pin_n = (rst_cnt_q == '0);

endmodule : dpst_host

// File: dpst_assertions.sv
// Checker of the busy timing seen on the link pins.
`timescale 1ns/1ps
module dpst_assertions
  import dpst_pkg::*;
#(
  parameter int unsigned PROG_CYCLES  = PROG_CYC,
  parameter int unsigned RDSTO_CYCLES = RD_STORE_CYC,
  parameter int unsigned PWRUP_CYCLES = POWER_UP_CYC
) (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic arst_n,
  // Link pins
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic done,
  input wire logic reset_pin_n
);
  // ------------------------------------------------
  // Frame decode
  // ------------------------------------------------
  // Limits allow three link cycles for select and done synchronisers; the restore limit allows four.
  localparam int WR_LIM   = WR_NORM_CYC + 3;
  localparam int PERF_LIM = WR_PERF_CYC + 3;
  localparam int RDW_LIM  = RD_WIPER_CYC + 3;
  localparam int PROG_LIM = PROG_CYCLES + 3;
  localparam int RDS_LIM  = RDSTO_CYCLES + 3;
  localparam int BOOT_LIM = PWRUP_CYCLES + 4;
  logic [FRAME_BITS-1:0] shift_q;
  logic [3:0]            cmd_q;
  logic [1:0]            pins_q;
  logic                  perf_q;
  int                    busy_q;

  always_ff @(negedge sclk or negedge arst_n)
    if (!arst_n)
      shift_q <= '0;
    else
      shift_q <= {shift_q[FRAME_BITS-2:0], sdi};

  always_ff @(posedge link_clk or negedge arst_n)
    if (!arst_n)
      pins_q <= 2'h3;
    else
      pins_q <= {sel_n, reset_pin_n};

  // A restore, at power-on or by the reset pin, is tracked as code F.
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      cmd_q <= 4'hF;
    else if (reset_pin_n && !pins_q[0])
      cmd_q <= 4'hF;
    else if (sel_n && !pins_q[1])
      cmd_q <= shift_q[CMD_MSB:CMD_LSB];
  end

  always_ff @(posedge link_clk or negedge arst_n)
    if (!arst_n)
      perf_q <= 1'b0;
    else if (sel_n && !pins_q[1] && shift_q[CMD_MSB:CMD_LSB] == 4'h6)
      perf_q <= shift_q[0];

  always_ff @(posedge link_clk or negedge arst_n)
    if (!arst_n)
      busy_q <= 0;
    else
      busy_q <= done ? 0 : busy_q + 1;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!arst_n);
  sequence sel_rise;
    $rose(sel_n);
  endsequence
  sequence busy_seen;
    ##[1:6] !done;
  endsequence

  busy_fall_a: assert property (sel_rise |-> busy_seen)
    else $error("done did not fall after select rise");
  frame_ready_a: assert property (!sel_n |-> done)
    else $error("done low while a frame is open");
  clock_idle_a: assert property (sel_n && $past(sel_n) |-> !sclk)
    else $error("serial clock high outside a frame");
  write_norm_a: assert property
    (cmd_q == 4'h1 && !perf_q |-> busy_q <= WR_LIM)
    else $error("normal write busy too long");
  write_perf_a: assert property
    (cmd_q == 4'h1 && perf_q |-> busy_q <= PERF_LIM)
    else $error("precision write busy too long");
  read_wiper_a: assert property (cmd_q == 4'h2 |-> busy_q <= RDW_LIM)
    else $error("wiper readback busy too long");
  program_time_a: assert property (cmd_q == 4'h3 |-> busy_q <= PROG_LIM)
    else $error("program busy too long");
  read_store_a: assert property (cmd_q == 4'h5 |-> busy_q <= RDS_LIM)
    else $error("store readback busy too long");
  restore_time_a: assert property (cmd_q == 4'hF |-> busy_q <= BOOT_LIM)
    else $error("restore busy too long");
  other_cmd_a: assert property
    (cmd_q == 4'h0 || cmd_q == 4'h6 |-> busy_q <= 5)
    else $error("short command busy too long");
endmodule // dpst_assertions

// File: digipot_serial_busy_timing_tb.sv
// Self-checking bench joining the host and device ends.
`timescale 1ns/1ps
module digipot_serial_busy_timing_tb;
  import dpst_pkg::*;
  typedef struct {
    logic [15:0] frame;
    logic [9:0]  wiper;
    logic        perf;
    logic [4:0]  used;
    logic        chk;
  } dpst_row_t;
  localparam int SIM_CYC = 20;
  logic              clk = 1'b0;
  logic              link_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              pin_reset_req = 1'b0;
  logic [15:0]       cmd_frame = 16'h0000;
  logic              cmd_ready;
  logic              rsp_valid;
  logic [15:0]       rsp_data;
  logic [15:0]       last_rsp;
  logic [9:0]        wiper_setting;
  logic              perf_mode;
  logic [4:0]        store_used;
  int                bad_count = 0;
  int                checks_done = 0;
  int                cycles = 0;
  dpst_row_t         rows [9];

  always #25 clk = ~clk;
  initial
  begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  dpst_if ifc ();
  dpst_host dpst_host_i (.clk(clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_frame(cmd_frame),
    .pin_reset_req(pin_reset_req), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .bus(ifc));
  dpst_device #(.PROG_CYCLES(SIM_CYC), .RDSTO_CYCLES(SIM_CYC),
    .PWRUP_CYCLES(SIM_CYC)) dpst_device_i (.link_clk(link_clk),
    .arst_n(arst_n), .bus(ifc), .wiper_setting(wiper_setting),
    .perf_mode(perf_mode), .store_used(store_used));
  dpst_assertions #(.PROG_CYCLES(SIM_CYC), .RDSTO_CYCLES(SIM_CYC),
    .PWRUP_CYCLES(SIM_CYC)) dpst_assertions_i (.link_clk(link_clk),
    .arst_n(arst_n), .sel_n(ifc.sel_n), .sclk(ifc.sclk), .sdi(ifc.sdi),
    .done(ifc.done), .reset_pin_n(ifc.reset_pin_n));

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_flag(input bit rsp);
    int n;
    n = 0;
    while ((rsp ? rsp_valid : cmd_ready) !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    cmp(rsp ? "rsp_valid" : "cmd_ready", 16'h0001, {15'h0000, n < 4000});
  endtask

  // The host waits for done itself; cmd_ready reflects that.
  task automatic send(input logic [15:0] f);
    wait_flag(1'b0);
    cmd_frame = f;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_flag(1'b1);
    last_rsp = rsp_data;
    wait_flag(1'b0);
  endtask

  // Ceiling is several times the expected run of about 10000 cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    rows[0] = '{16'h1155, 10'h155, 1'b0, 5'h00, 1'b0};
    rows[1] = '{16'h2000, 10'h155, 1'b0, 5'h00, 1'b0};
    rows[2] = '{16'h0000, 10'h155, 1'b0, 5'h00, 1'b1};
    rows[3] = '{16'h6001, 10'h155, 1'b1, 5'h00, 1'b0};
    rows[4] = '{16'h13FF, 10'h3FF, 1'b1, 5'h00, 1'b0};
    rows[5] = '{16'h3000, 10'h3FF, 1'b1, 5'h01, 1'b0};
    rows[6] = '{16'h1000, 10'h000, 1'b1, 5'h01, 1'b0};
    rows[7] = '{16'h5000, 10'h000, 1'b1, 5'h01, 1'b0};
    rows[8] = '{16'h6000, 10'h000, 1'b0, 5'h01, 1'b0};
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    wait_flag(1'b0);
    cmp("wiper", 16'h0200, {6'h00, wiper_setting});
    foreach (rows[i])
    begin
      send(rows[i].frame);
      cmp("wiper", {6'h00, rows[i].wiper}, {6'h00, wiper_setting});
      cmp("perf", {15'h0000, rows[i].perf}, {15'h0000, perf_mode});
      cmp("used", {11'h000, rows[i].used}, {11'h000, store_used});
      if (rows[i].chk)
        cmp("readback", {6'h00, rows[i].wiper}, {6'h00, last_rsp[9:0]});
    end
    send(16'h13FF);
    send(16'h3000);
    send(16'h1044);
    pin_reset_req = 1'b1;
    repeat (4) @(negedge clk);
    pin_reset_req = 1'b0;
    repeat (60) @(negedge clk);
    wait_flag(1'b0);
    cmp("reload", 16'h03FF, {6'h00, wiper_setting});
    // Past the store depth a program is ignored yet still busy.
    repeat (STORE_DEPTH) send(16'h3000);
    cmp("full", 16'(STORE_DEPTH), {11'h000, store_used});
    // Power reset in mid-frame must leave the port usable.
    cmd_frame = 16'h1123;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (10) @(negedge clk);
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    send(16'h1123);
    cmp("wiper", 16'h0123, {6'h00, wiper_setting});
    complete_run();
  end
endmodule // digipot_serial_busy_timing_tb
